// ==== bit_flag_pkg.sv ====
package bit_flag_pkg;
    // flag positions inside the core flag word
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    // base cycle counts and the internal sram penalty
    localparam logic [1:0] BIT_OP_CYCLES = 2'h1;
    localparam logic [1:0] SRAM_EXTRA    = 2'h1;

    typedef enum logic [4:0] {
        OP_NONE,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_ARITH_SHIFT_RIGHT,
        OP_IO_BIT_FORCE_HIGH,
        OP_IO_BIT_FORCE_LOW,
        OP_BIT_TO_TRANSFER_FLAG,
        OP_TRANSFER_FLAG_TO_BIT,
        OP_SIGNED_FLAG_FORCE_HIGH,
        OP_SIGNED_FLAG_FORCE_LOW,
        OP_OVERFLOW_FLAG_FORCE_HIGH,
        OP_OVERFLOW_FLAG_FORCE_LOW,
        OP_HALF_CARRY_FORCE_HIGH,
        OP_HALF_CARRY_FORCE_LOW,
        OP_MEM_ACCESS
    } op_t;
endpackage : bit_flag_pkg

// ==== mem_timing_if.sv ====
`timescale 1ns/100ps
// carries a memory access request to the timing counter and its busy answer
interface mem_timing_if;
    logic       start;
    logic [1:0] base_cycles;
    logic       internal_sram;
    logic       busy;
    logic       done;
    modport ctrl (output start, output base_cycles, output internal_sram, input busy, input done);
    modport tmr  (input start, input base_cycles, input internal_sram, output busy, output done);
endinterface : mem_timing_if

// ==== mem_access_timer.sv ====
`timescale 1ns/100ps
module mem_access_timer
    import bit_flag_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire logic    sys_rst,
    mem_timing_if.tmr    mt
);
    typedef struct packed {
        logic [2:0] left;
        logic       done;
    } tmr_state_t;
    tmr_state_t st_r;
    tmr_state_t st_nxt;

    // count down the listed cycles plus one for internal sram
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (st_r.left != 3'h0) begin
            st_nxt.left = st_r.left - 3'h1;
            if (st_r.left == 3'h1) begin
                st_nxt.done = 1'b1;
            end
        end else if (mt.start) begin
            st_nxt.left = {1'b0, mt.base_cycles} + (mt.internal_sram ? {1'b0, SRAM_EXTRA} : 3'h0);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mt.busy = (st_r.left != 3'h0);
    assign mt.done = st_r.done;

    a_sram_extra_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mt.start && !mt.busy && mt.internal_sram && mt.base_cycles == 2'h1) |=> mt.busy ##1 mt.busy ##1 mt.done)
        else $error("internal sram access did not take one extra cycle");
    a_ext_no_extra: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mt.start && !mt.busy && !mt.internal_sram && mt.base_cycles == 2'h1) |=> mt.busy ##1 mt.done)
        else $error("non sram access length wrong");
endmodule : mem_access_timer

// ==== bit_flag_instruction_unit.sv ====
`timescale 1ns/100ps
// Operation
// - rotate left: carry into bit 0, bit 7 into carry; z,c,n,v,h updated
// - rotate right: carry into bit 7, bit 0 into carry; z,c,n,v updated
// - io bit force high sets chosen io bit, other bits and flags kept
// - io bit force low clears chosen io bit, other bits and flags kept
// - chosen source register bit copied into transfer flag only
// - transfer flag copied into chosen destination bit, flags kept
// - signed flag forced high or low, other flags kept
// - overflow flag forced high or low, other flags kept
// - half carry forced high or low, other flags kept
// - internal sram data access takes one cycle more than listed
module bit_flag_instruction_unit
    import bit_flag_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              op_valid,
    input  wire bit_flag_pkg::op_t op_code,
    input  wire logic [2:0]        bit_sel,
    input  wire logic [7:0]        reg_operand,
    input  wire logic [7:0]        io_operand,
    input  wire logic [1:0]        mem_base_cycles,
    input  wire logic              mem_internal_sram,
    output logic                   op_ready,
    output logic [7:0]             reg_result,
    output logic                   reg_write,
    output logic [7:0]             io_result,
    output logic                   io_write,
    output logic [7:0]             core_flag_word,
    output logic                   mem_done
);
    import bit_flag_pkg::*;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] reg_res;
        logic       reg_wr;
        logic [7:0] io_res;
        logic       io_wr;
    } unit_state_t;
    unit_state_t st_r;
    unit_state_t st_nxt;

    mem_timing_if mt ();

    mem_access_timer u_timer (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .mt      (mt)
    );

    // one-hot mask for the selected bit position
    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = 8'h01 << b;
    endfunction : bit_mask

    // shared zero, negative and overflow update of the shift group
    function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] res, input logic c);
        logic [7:0] o;
        o = f;
        o[FLAG_C] = c;
        o[FLAG_Z] = (res == 8'h00);
        o[FLAG_N] = res[7];
        o[FLAG_V] = res[7] ^ c;
        shift_flags = o;
    endfunction : shift_flags

    logic accept;
    assign accept = op_valid && !mt.busy;
    // stall new operations while a memory access is still counting
    assign op_ready = !mt.busy;
    assign mt.start = accept && (op_code == OP_MEM_ACCESS);
    assign mt.base_cycles = mem_base_cycles;
    assign mt.internal_sram = mem_internal_sram;

    // every bit and flag operation finishes in the cycle it is accepted
    always_comb begin
        st_nxt = st_r;
        st_nxt.reg_wr = 1'b0;
        st_nxt.io_wr = 1'b0;
        if (accept) begin
            case (op_code)
                OP_ROTATE_LEFT_CARRY: begin
                    st_nxt.reg_res = {reg_operand[6:0], st_r.flags[FLAG_C]};
                    st_nxt.reg_wr = 1'b1;
                    st_nxt.flags = shift_flags(st_r.flags, {reg_operand[6:0], st_r.flags[FLAG_C]},
                                               reg_operand[7]);
                    st_nxt.flags[FLAG_H] = reg_operand[3];
                end
                OP_ROTATE_RIGHT_CARRY: begin
                    st_nxt.reg_res = {st_r.flags[FLAG_C], reg_operand[7:1]};
                    st_nxt.reg_wr = 1'b1;
                    st_nxt.flags = shift_flags(st_r.flags, {st_r.flags[FLAG_C], reg_operand[7:1]},
                                               reg_operand[0]);
                end
                OP_ARITH_SHIFT_RIGHT: begin
                    st_nxt.reg_res = {reg_operand[7], reg_operand[7:1]};
                    st_nxt.reg_wr = 1'b1;
                    st_nxt.flags = shift_flags(st_r.flags, {reg_operand[7], reg_operand[7:1]},
                                               reg_operand[0]);
                end
                OP_IO_BIT_FORCE_HIGH: begin
                    st_nxt.io_res = io_operand | bit_mask(bit_sel);
                    st_nxt.io_wr = 1'b1;
                end
                OP_IO_BIT_FORCE_LOW: begin
                    st_nxt.io_res = io_operand & ~bit_mask(bit_sel);
                    st_nxt.io_wr = 1'b1;
                end
                OP_BIT_TO_TRANSFER_FLAG: begin
                    st_nxt.flags[FLAG_T] = reg_operand[bit_sel];
                end
                OP_TRANSFER_FLAG_TO_BIT: begin
                    st_nxt.reg_res = st_r.flags[FLAG_T] ? (reg_operand | bit_mask(bit_sel))
                                                        : (reg_operand & ~bit_mask(bit_sel));
                    st_nxt.reg_wr = 1'b1;
                end
                OP_SIGNED_FLAG_FORCE_HIGH:   st_nxt.flags[FLAG_S] = 1'b1;
                OP_SIGNED_FLAG_FORCE_LOW:    st_nxt.flags[FLAG_S] = 1'b0;
                OP_OVERFLOW_FLAG_FORCE_HIGH: st_nxt.flags[FLAG_V] = 1'b1;
                OP_OVERFLOW_FLAG_FORCE_LOW:  st_nxt.flags[FLAG_V] = 1'b0;
                OP_HALF_CARRY_FORCE_HIGH:    st_nxt.flags[FLAG_H] = 1'b1;
                OP_HALF_CARRY_FORCE_LOW:     st_nxt.flags[FLAG_H] = 1'b0;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r.flags <= FLAGS_RESET;
            st_r.reg_res <= DATA_RESET;
            st_r.reg_wr <= 1'b0;
            st_r.io_res <= DATA_RESET;
            st_r.io_wr <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_result = st_r.reg_res;
    assign reg_write = st_r.reg_wr;
    assign io_result = st_r.io_res;
    assign io_write = st_r.io_wr;
    assign core_flag_word = st_r.flags;
    assign mem_done = mt.done;

    // helpers: operation accepted one cycle earlier
    logic       acc_d;
    op_t        op_d;
    logic [7:0] opnd_d;
    logic [7:0] io_d;
    logic [2:0] b_d;
    logic [7:0] f_d;
    always_ff @(posedge clk_sys) begin
        acc_d <= accept && !sys_rst;
        op_d <= op_code;
        opnd_d <= reg_operand;
        io_d <= io_operand;
        b_d <= bit_sel;
        f_d <= st_r.flags;
    end

    a_rotl_result: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_ROTATE_LEFT_CARRY) |-> (reg_write && reg_result == {opnd_d[6:0], f_d[FLAG_C]}
        && core_flag_word[FLAG_C] == opnd_d[7] && core_flag_word[FLAG_H] == opnd_d[3]))
        else $error("rotate left result or carry wrong");
    a_rotr_result: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_ROTATE_RIGHT_CARRY) |-> (reg_result == {f_d[FLAG_C], opnd_d[7:1]}
        && core_flag_word[FLAG_C] == opnd_d[0]))
        else $error("rotate right result or carry wrong");
    a_io_set_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_IO_BIT_FORCE_HIGH) |-> (io_write && io_result == (io_d | (8'h01 << b_d))
        && core_flag_word == f_d))
        else $error("io bit set wrong");
    a_io_clr_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_IO_BIT_FORCE_LOW) |-> (io_write && io_result == (io_d & ~(8'h01 << b_d))
        && core_flag_word == f_d))
        else $error("io bit clear wrong");
    a_bit_store_t: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_BIT_TO_TRANSFER_FLAG) |-> (core_flag_word[FLAG_T] == opnd_d[b_d]
        && core_flag_word[5:0] == f_d[5:0] && !reg_write))
        else $error("bit store to transfer flag wrong");
    a_bit_load_t: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_TRANSFER_FLAG_TO_BIT) |-> (reg_result[b_d] == f_d[FLAG_T]
        && (reg_result & ~(8'h01 << b_d)) == (opnd_d & ~(8'h01 << b_d)) && core_flag_word == f_d))
        else $error("bit load from transfer flag wrong");
    a_signed_force: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_SIGNED_FLAG_FORCE_HIGH) |-> (core_flag_word == (f_d | 8'h10)))
        else $error("signed flag force wrong");
    a_signed_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_SIGNED_FLAG_FORCE_LOW) |-> (core_flag_word == (f_d & 8'hef)))
        else $error("signed flag clear wrong");
    a_ovf_force: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_OVERFLOW_FLAG_FORCE_LOW) |-> (core_flag_word == (f_d & 8'hf7)))
        else $error("overflow flag force wrong");
    a_ovf_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_OVERFLOW_FLAG_FORCE_HIGH) |-> (core_flag_word == (f_d | 8'h08)))
        else $error("overflow flag set wrong");
    a_half_force: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_HALF_CARRY_FORCE_HIGH) |-> (core_flag_word == (f_d | 8'h20)))
        else $error("half carry force wrong");
    a_half_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_HALF_CARRY_FORCE_LOW) |-> (core_flag_word == (f_d & 8'hdf)))
        else $error("half carry clear wrong");
    a_shift_nv: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && (op_d == OP_ROTATE_RIGHT_CARRY || op_d == OP_ROTATE_LEFT_CARRY)) |->
        (core_flag_word[FLAG_V] == (core_flag_word[FLAG_N] ^ core_flag_word[FLAG_C])
        && core_flag_word[FLAG_Z] == (reg_result == 8'h00)))
        else $error("rotate zero or overflow flag wrong");
    a_asr_keep7: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (acc_d && op_d == OP_ARITH_SHIFT_RIGHT) |-> (reg_result == {opnd_d[7], opnd_d[7:1]}
        && core_flag_word[FLAG_C] == opnd_d[0]))
        else $error("arithmetic shift right wrong");

    c_rotl: cover property (@(posedge clk_sys) accept && op_code == OP_ROTATE_LEFT_CARRY);
    c_io_set: cover property (@(posedge clk_sys) accept && op_code == OP_IO_BIT_FORCE_HIGH);
    c_bit_load: cover property (@(posedge clk_sys) accept && op_code == OP_TRANSFER_FLAG_TO_BIT);
    c_flag_force: cover property (@(posedge clk_sys) accept && op_code == OP_SIGNED_FLAG_FORCE_HIGH);
    c_sram: cover property (@(posedge clk_sys) mt.start && mem_internal_sram ##[1:8] mem_done);
endmodule : bit_flag_instruction_unit

// ==== operand_store.sv ====
`timescale 1ns/100ps
// stands in for the register file and io space that feed the unit
module operand_store (
    input  wire logic       clk_sys,
    input  wire logic       load_en,
    input  wire logic [7:0] load_reg,
    input  wire logic [7:0] load_io,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_result,
    input  wire logic       io_write,
    input  wire logic [7:0] io_result,
    output logic      [7:0] reg_operand,
    output logic      [7:0] io_operand
);
    // write pulses land at their edge; a preload wins since the bench never overlaps them
    always_ff @(posedge clk_sys) begin
        if (load_en) begin
            reg_operand <= load_reg;
            io_operand  <= load_io;
        end else begin
            if (reg_write) reg_operand <= reg_result;
            if (io_write) io_operand <= io_result;
        end
    end
endmodule : operand_store

// ==== bit_flag_instruction_unit_bench.sv ====
`timescale 1ns/100ps
module bit_flag_instruction_unit_bench;
    import bit_flag_pkg::*;
    logic       clk_sys, sys_rst = 1'b1, op_valid = 1'b0, load_en = 1'b0, mem_internal_sram = 1'b0;
    op_t        op_code = OP_NONE;
    logic [2:0] bit_sel = 3'h0;
    logic [1:0] mem_base_cycles = 2'h1;
    logic [7:0] reg_operand, io_operand, reg_result, io_result, core_flag_word, load_reg, load_io;
    logic       op_ready, reg_write, io_write, mem_done;
    logic [7:0] exp_f = FLAGS_RESET;
    int         n_fail = 0;
    int         checked = 0;
    logic       hung = 1'b0;

    bit_flag_instruction_unit dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .bit_sel(bit_sel), .reg_operand(reg_operand), .io_operand(io_operand),
        .mem_base_cycles(mem_base_cycles), .mem_internal_sram(mem_internal_sram), .op_ready(op_ready),
        .reg_result(reg_result), .reg_write(reg_write), .io_result(io_result), .io_write(io_write),
        .core_flag_word(core_flag_word), .mem_done(mem_done));
    operand_store far_side (.clk_sys(clk_sys), .load_en(load_en), .load_reg(load_reg), .load_io(load_io),
        .reg_write(reg_write), .reg_result(reg_result), .io_write(io_write), .io_result(io_result),
        .reg_operand(reg_operand), .io_operand(io_operand));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    // preload operands, issue one op, then compare writes, results and flags one cycle on
    task run(input op_t op, input logic [2:0] sel, input logic [7:0] r, input logic [7:0] io);
        logic [7:0] er, ei;
        logic [1:0] ew;
        @(negedge clk_sys);
        load_en = 1'b1;
        load_reg = r;
        load_io = io;
        @(negedge clk_sys);
        load_en = 1'b0;
        op_valid = 1'b1;
        op_code = op;
        bit_sel = sel;
        er = r;
        ei = io;
        ew = 2'h0;
        case (op)
            OP_ROTATE_LEFT_CARRY: begin
                er = {r[6:0], exp_f[FLAG_C]};
                exp_f[FLAG_H] = r[3];
            end
            OP_ROTATE_RIGHT_CARRY: er = {exp_f[FLAG_C], r[7:1]};
            OP_ARITH_SHIFT_RIGHT: er = {r[7], r[7:1]};
            OP_IO_BIT_FORCE_HIGH: ei[sel] = 1'b1;
            OP_IO_BIT_FORCE_LOW: ei[sel] = 1'b0;
            OP_BIT_TO_TRANSFER_FLAG: exp_f[FLAG_T] = r[sel];
            OP_TRANSFER_FLAG_TO_BIT: er[sel] = exp_f[FLAG_T];
            OP_SIGNED_FLAG_FORCE_HIGH: exp_f[FLAG_S] = 1'b1;
            OP_SIGNED_FLAG_FORCE_LOW: exp_f[FLAG_S] = 1'b0;
            OP_OVERFLOW_FLAG_FORCE_HIGH: exp_f[FLAG_V] = 1'b1;
            OP_OVERFLOW_FLAG_FORCE_LOW: exp_f[FLAG_V] = 1'b0;
            OP_HALF_CARRY_FORCE_HIGH: exp_f[FLAG_H] = 1'b1;
            OP_HALF_CARRY_FORCE_LOW: exp_f[FLAG_H] = 1'b0;
            default: ;
        endcase
        // shifts: carry from the bit shifted out, then z, n and v from the result
        if (op inside {OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT}) begin
            exp_f[FLAG_C] = (op == OP_ROTATE_LEFT_CARRY) ? r[7] : r[0];
            exp_f[FLAG_Z] = (er == 8'h00);
            exp_f[FLAG_N] = er[7];
            exp_f[FLAG_V] = er[7] ^ exp_f[FLAG_C];
        end
        if (op inside {OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT,
                       OP_TRANSFER_FLAG_TO_BIT}) ew = 2'h2;
        if (op inside {OP_IO_BIT_FORCE_HIGH, OP_IO_BIT_FORCE_LOW}) ew = 2'h1;
        @(negedge clk_sys);
        op_valid = 1'b0;
        check({6'h00, reg_write, io_write}, {6'h00, ew});
        if (ew[1]) check(reg_result, er);
        if (ew[0]) check(io_result, ei);
        check(core_flag_word, exp_f);
    endtask : run

    // memory access; a flag op offered while counting must be ignored
    task mem(input logic [1:0] base, input logic sram);
        int k;
        @(negedge clk_sys);
        op_valid = 1'b1;
        op_code = OP_MEM_ACCESS;
        mem_base_cycles = base;
        mem_internal_sram = sram;
        @(negedge clk_sys);
        op_code = OP_SIGNED_FLAG_FORCE_HIGH;
        check({7'h00, op_ready}, 8'h00);
        k = 0;
        while (mem_done !== 1'b1 && k < 8) begin
            @(negedge clk_sys);
            op_valid = 1'b0;
            k++;
        end
        check(8'(k), 8'(base) + 8'(sram));
        check({7'h00, op_ready}, 8'h01);
        if (k == 8) hung = 1'b1;
        @(negedge clk_sys);
        check(core_flag_word, exp_f);
    endtask : mem

    initial begin
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        check(core_flag_word, FLAGS_RESET);
        check({7'h00, op_ready}, 8'h01);
        run(OP_ROTATE_LEFT_CARRY, 3'h0, 8'h81, 8'h00);
        run(OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h01, 8'h00);
        run(OP_ARITH_SHIFT_RIGHT, 3'h0, 8'h01, 8'h00);
        run(OP_ARITH_SHIFT_RIGHT, 3'h0, 8'hc2, 8'h00);
        run(OP_ROTATE_LEFT_CARRY, 3'h0, 8'h08, 8'h00);
        run(OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h00, 8'h00);
        $display("shift test done");
        for (int i = 0; i < 8; i++) begin
            run(OP_IO_BIT_FORCE_HIGH, 3'(i), 8'h00, 8'h5a);
            run(OP_IO_BIT_FORCE_LOW, 3'(i), 8'h00, 8'ha5);
            run(OP_BIT_TO_TRANSFER_FLAG, 3'(i), 8'h96, 8'h00);
            run(OP_TRANSFER_FLAG_TO_BIT, 3'(7 - i), 8'h3c, 8'h00);
        end
        $display("bit test done");
        for (int j = 0; j < 2; j++) begin
            run(OP_SIGNED_FLAG_FORCE_HIGH, 3'h0, 8'h00, 8'h00);
            run(OP_OVERFLOW_FLAG_FORCE_LOW, 3'h0, 8'h00, 8'h00);
            run(OP_HALF_CARRY_FORCE_HIGH, 3'h0, 8'h00, 8'h00);
            run(OP_SIGNED_FLAG_FORCE_LOW, 3'h0, 8'h00, 8'h00);
            run(OP_OVERFLOW_FLAG_FORCE_HIGH, 3'h0, 8'h00, 8'h00);
            run(OP_HALF_CARRY_FORCE_LOW, 3'h0, 8'h00, 8'h00);
            run(OP_NONE, 3'h0, 8'h5a, 8'ha5);
        end
        $display("flag test done");
        for (int b = 1; b < 4 && !hung; b++) begin
            mem(2'(b), 1'b0);
            mem(2'(b), 1'b1);
        end
        $display("memory test done");
        results();
    end
endmodule : bit_flag_instruction_unit_bench
